// [hdl/xoc_crystal_osc_ctrl.sv]
// crystal oscillator control: main oscillator gating, settling, ready irq and slow pin override
// What this block does
// RL1 - enable low keeps main oscillator off
// RL2 - on-request: idle runs on request, standby off
// RL3 - standby-run: runs in idle and standby
// RL4 - both set: runs only on request
// RL5 - settle period after reset or wake
// RL6 - mask oscillator output while settling
// RL7 - ready flag set when settling ends
// RL8 - ready rise raises enabled interrupt, but not a main ready rise at the edge where the main oscillator stops
// RL9 - software waits ready before entering standby
// RL10 - slow oscillator: external clock or crystal
// RL11 - power-on reset leaves slow oscillator off
// RL12 - crystal mode overrides both slow pins
// RL13 - external mode overrides input pin only
// RL14 - enable write starts selected slow mode
// RL15 - crystal select one crystal, zero external
// RL16 - disable by writing zero, others unchanged
// RL17 - ready clears whenever oscillator stops
//
// Added by the designer: the address-and-strobe port and the register addresses.
module xoc_crystal_osc_ctrl
  import xoc_pkg::*;
#(
  parameter int SETTLE_CNT_W_P = SETTLE_CNT_W
) (
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  input  wire logic [7:0]  regAddr,
  input  wire logic [31:0] regWrData,
  input  wire logic        regWrStb,
  input  wire logic        regRdStb,
  input  wire logic [1:0]  sleepMode,
  input  wire logic        periphClkReq,
  input  wire logic        mainOscClkIn,
  input  wire logic        slowXtalIn,
  output logic [31:0]      regRdData,
  output logic             mainOscRun,
  output logic             mainOscClkOut,
  output logic             slowOscRun,
  output logic             slowXtalMode,
  output logic             slowXtalInOvr,
  output logic             slowXtalOutOvr,
  output logic             slowClkOut,
  output logic             irqOut
);

  // ==========================================================
  // registers
  xoc_main_cfg_t          mainCfg_ff;
  xoc_slow_cfg_t          slowCfg_ff;
  logic                   mainRun_ff;
  logic                   mainReady_ff;
  logic                   slowReady_ff;
  logic [SETTLE_CNT_W_P-1:0] settleCnt_ff;
  logic [IRQ_W-1:0]       irqFlag_ff;
  logic [IRQ_W-1:0]       irqEn_ff;
  logic [31:0]            rdData_ff;
  logic                   clkOut_ff;
  logic                   slowClk_ff;
  logic                   irq_ff;
  xoc_pin_ovr_t           pinOvr_ff;

  logic                   nxt_mainRun;
  logic [IRQ_W-1:0]       readyRise;
  logic [SETTLE_CNT_W_P-1:0] settleTarget;
  xoc_sleep_t             sleepState;

  function automatic logic wrHit(input logic [7:0] a);
    wrHit = regWrStb && (regAddr == a);
  endfunction

  assign sleepState = xoc_sleep_t'(sleepMode);

  // ==========================================================
  // main oscillator run decision
  always_comb begin
    nxt_mainRun = 1'b0;
    if (!mainCfg_ff.enable) begin
      nxt_mainRun = 1'b0; // RL1
    end else begin
      unique case (sleepState)
        SLEEP_ACTIVE:
          nxt_mainRun = !mainCfg_ff.onRequest || periphClkReq;
        SLEEP_IDLE:
          nxt_mainRun = !mainCfg_ff.onRequest || periphClkReq; // RL2 RL3 RL4
        SLEEP_STANDBY: begin
          // standby runs only with standby-run set; on-request then gates it
          if (!mainCfg_ff.run_in_standby) nxt_mainRun = 1'b0; // RL2
          else nxt_mainRun = !mainCfg_ff.onRequest || periphClkReq; // RL3 RL4
        end
        default:
          nxt_mainRun = 1'b0;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) mainRun_ff <= 1'b0;
    else mainRun_ff <= nxt_mainRun;
  end

  // ==========================================================
  // settling counter: restarts on every off-to-on transition
  assign settleTarget = SETTLE_CNT_W_P'((SETTLE_CNT_W_P+1)'(1) << mainCfg_ff.settleSel);

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      settleCnt_ff <= '0;
      mainReady_ff <= 1'b0;
    end else if (!mainRun_ff) begin
      settleCnt_ff <= '0; // RL5
      mainReady_ff <= 1'b0; // RL17
    end else if (!mainReady_ff) begin
      if (settleCnt_ff >= settleTarget - SETTLE_CNT_W_P'(1)) begin
        mainReady_ff <= 1'b1; // RL7
      end else begin
        settleCnt_ff <= settleCnt_ff + SETTLE_CNT_W_P'(1); // RL5
      end
    end
  end

  // output masked until ready; gating a clock by a flop here is a model, not a glitch-free gate
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) clkOut_ff <= 1'b0;
    else clkOut_ff <= mainOscClkIn && mainReady_ff && mainRun_ff; // RL6
  end

  // ==========================================================
  // slow oscillator: pin override and clock pass-through
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pinOvr_ff    <= '0; // RL11
      slowReady_ff <= 1'b0;
      slowClk_ff   <= 1'b0;
    end else begin
      pinOvr_ff.inOverride  <= slowCfg_ff.enable; // RL13
      pinOvr_ff.outOverride <= slowCfg_ff.enable && slowCfg_ff.crystalSelect; // RL12
      slowReady_ff          <= slowCfg_ff.enable; // RL14
      slowClk_ff            <= slowCfg_ff.enable && slowXtalIn; // RL10
    end
  end

  // ==========================================================
  // interrupts: set wins over clear
  assign readyRise = {slowCfg_ff.enable && !slowReady_ff, nxt_mainRun && mainRun_ff
                      && !mainReady_ff && (settleCnt_ff >= settleTarget - SETTLE_CNT_W_P'(1))};

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) irqFlag_ff <= '0;
    else if (wrHit(IRQ_CLR_ADDR))
      irqFlag_ff <= (irqFlag_ff & ~regWrData[IRQ_W-1:0]) | readyRise; // RL8
    else irqFlag_ff <= irqFlag_ff | readyRise; // RL8
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) irqEn_ff <= '0;
    else if (wrHit(IRQ_ENSET_ADDR)) irqEn_ff <= irqEn_ff | regWrData[IRQ_W-1:0];
    else if (wrHit(IRQ_ENCLR_ADDR)) irqEn_ff <= irqEn_ff & ~regWrData[IRQ_W-1:0];
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) irq_ff <= 1'b0;
    else irq_ff <= |(irqFlag_ff & irqEn_ff); // RL8
  end

  // ==========================================================
  // control registers
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      mainCfg_ff <= '{run_in_standby: 1'b0, onRequest: 1'b0, enable: 1'b0, settleSel: SETTLE_RST};
    end else if (wrHit(MAIN_CTRL_ADDR)) begin
      mainCfg_ff.enable    <= regWrData[MAIN_ENABLE_BIT];
      mainCfg_ff.run_in_standby  <= regWrData[MAIN_STDBY_BIT];
      mainCfg_ff.onRequest <= regWrData[MAIN_ONREQ_BIT];
      mainCfg_ff.settleSel <= regWrData[SETTLE_LSB +: SETTLE_W]; // RL5
    end
  end

  // a whole-register write; software keeps the other bits when disabling
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) slowCfg_ff <= '0; // RL11
    else if (wrHit(SLOW_CTRL_ADDR)) begin
      slowCfg_ff.enable        <= regWrData[SLOW_ENABLE_BIT]; // RL14 RL16
      slowCfg_ff.crystalSelect <= regWrData[SLOW_XTAL_BIT]; // RL15
    end
  end

  // ==========================================================
  // read port: data valid in the cycle after the strobe only
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) rdData_ff <= '0;
    else if (!regRdStb) rdData_ff <= '0;
    else begin
      rdData_ff <= '0;
      unique case (regAddr)
        MAIN_CTRL_ADDR: begin
          rdData_ff[MAIN_ENABLE_BIT]            <= mainCfg_ff.enable;
          rdData_ff[MAIN_STDBY_BIT]             <= mainCfg_ff.run_in_standby;
          rdData_ff[MAIN_ONREQ_BIT]             <= mainCfg_ff.onRequest;
          rdData_ff[SETTLE_LSB +: SETTLE_W]     <= mainCfg_ff.settleSel;
        end
        SLOW_CTRL_ADDR: begin
          rdData_ff[SLOW_ENABLE_BIT] <= slowCfg_ff.enable;
          rdData_ff[SLOW_XTAL_BIT]   <= slowCfg_ff.crystalSelect;
        end
        STATUS_ADDR: begin
          rdData_ff[MAIN_RDY_BIT] <= mainReady_ff; // RL7 RL9
          rdData_ff[SLOW_RDY_BIT] <= slowReady_ff;
        end
        IRQ_ENSET_ADDR: rdData_ff[IRQ_W-1:0] <= irqEn_ff;
        IRQ_ENCLR_ADDR: rdData_ff[IRQ_W-1:0] <= irqEn_ff;
        IRQ_FLAG_ADDR:  rdData_ff[IRQ_W-1:0] <= irqFlag_ff;
        default:        rdData_ff <= '0;
      endcase
    end
  end

  assign regRdData      = rdData_ff;
  assign mainOscRun     = mainRun_ff;
  assign mainOscClkOut  = clkOut_ff;
  assign slowOscRun     = slowReady_ff;
  assign slowXtalMode   = pinOvr_ff.outOverride;
  assign slowXtalInOvr  = pinOvr_ff.inOverride;
  assign slowXtalOutOvr = pinOvr_ff.outOverride;
  assign slowClkOut     = slowClk_ff;
  assign irqOut         = irq_ff;

endmodule

// [hdl/xoc_pkg.sv]
// package: register map, fields, timing and carrier types for the oscillator control block
package xoc_pkg;

  // ==========================================================
  // register offsets (byte addresses)
  localparam logic [7:0] MAIN_CTRL_ADDR  = 8'h00;
  localparam logic [7:0] SLOW_CTRL_ADDR  = 8'h04;
  localparam logic [7:0] STATUS_ADDR     = 8'h08;
  localparam logic [7:0] IRQ_ENSET_ADDR  = 8'h0c;
  localparam logic [7:0] IRQ_ENCLR_ADDR  = 8'h10;
  localparam logic [7:0] IRQ_FLAG_ADDR   = 8'h14;
  localparam logic [7:0] IRQ_CLR_ADDR    = 8'h18;

  // ==========================================================
  // main oscillator control fields
  localparam int MAIN_ENABLE_BIT  = 1;
  localparam int MAIN_STDBY_BIT   = 6;
  localparam int MAIN_ONREQ_BIT   = 7;
  localparam int SETTLE_LSB       = 12;
  localparam int SETTLE_W         = 4;

  // slow oscillator control fields
  localparam int SLOW_ENABLE_BIT  = 1;
  localparam int SLOW_XTAL_BIT    = 2;

  // status / interrupt bit positions
  localparam int MAIN_RDY_BIT     = 0;
  localparam int SLOW_RDY_BIT     = 1;
  localparam int IRQ_W            = 2;

  // ==========================================================
  // timing: settle length is 2^sel sys_clk cycles, counted on sys_clk and not on the main oscillator clock
  localparam int SETTLE_CNT_W     = 16;
  localparam logic [SETTLE_W-1:0] SETTLE_RST = 4'h0;

  typedef struct packed {
    logic                run_in_standby;
    logic                onRequest;
    logic                enable;
    logic [SETTLE_W-1:0] settleSel;
  } xoc_main_cfg_t;

  typedef struct packed {
    logic enable;
    logic crystalSelect;
  } xoc_slow_cfg_t;

  typedef struct packed {
    logic inOverride;
    logic outOverride;
  } xoc_pin_ovr_t;

  typedef enum logic [1:0] {
    SLEEP_ACTIVE,
    SLEEP_IDLE,
    SLEEP_STANDBY
  } xoc_sleep_t;

endpackage

// [verification/xoc_props.sv]
// checker: port-level properties of the oscillator control block
module xoc_props
  import xoc_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        rst_b,
  input wire logic [7:0]  regAddr,
  input wire logic [31:0] regWrData,
  input wire logic        regWrStb,
  input wire logic        regRdStb,
  input wire logic [31:0] regRdData,
  input wire logic        mainOscRun,
  input wire logic        mainOscClkOut,
  input wire logic        slowOscRun,
  input wire logic        slowXtalMode,
  input wire logic        slowXtalInOvr,
  input wire logic        slowXtalOutOvr,
  input wire logic        slowClkOut
);
  timeunit 1ns;
  timeprecision 100ps;
  // ====
  // properties
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  sequence s_slow_wr;
    regWrStb && regAddr == SLOW_CTRL_ADDR;
  endsequence
  sequence s_main_off_wr;
    regWrStb && regAddr == MAIN_CTRL_ADDR && !regWrData[MAIN_ENABLE_BIT];
  endsequence
  a_rd_idle_zero: assert property (!$past(regRdStb) |-> regRdData == 32'h0)
    else $error("read data not zero outside read cycle");
  a_slow_in_ovr: assert property (s_slow_wr |=> ##1
    slowXtalInOvr == $past(regWrData[SLOW_ENABLE_BIT], 2)) else $error("input override wrong");
  a_slow_out_ovr: assert property (s_slow_wr |=> ##1 slowXtalOutOvr ==
    $past(regWrData[SLOW_ENABLE_BIT] & regWrData[SLOW_XTAL_BIT], 2))
    else $error("output override wrong");
  a_mode_equal: assert property (slowXtalMode == slowXtalOutOvr)
    else $error("crystal mode differs from output override");
  a_run_in_ovr: assert property (slowOscRun == slowXtalInOvr)
    else $error("slow run differs from input override");
  a_out_needs_in: assert property (slowXtalOutOvr |-> slowXtalInOvr)
    else $error("output pin taken without input pin");
  a_slow_gated: assert property (!slowOscRun [*2] |-> !slowClkOut)
    else $error("slow clock passes while disabled");
  a_main_off: assert property (s_main_off_wr |=> ##1 !mainOscRun)
    else $error("main oscillator runs while disabled");
  a_mask_start: assert property ($rose(mainOscRun) |-> !mainOscClkOut)
    else $error("clock leaks at start of settling");
  a_mask_stop: assert property (!mainOscRun [*3] |-> !mainOscClkOut)
    else $error("clock leaks while stopped");
endmodule

bind xoc_crystal_osc_ctrl xoc_props i_xoc_props (.sys_clk(sys_clk), .rst_b(rst_b),
  .regAddr(regAddr), .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
  .regRdData(regRdData), .mainOscRun(mainOscRun), .mainOscClkOut(mainOscClkOut),
  .slowOscRun(slowOscRun), .slowXtalMode(slowXtalMode), .slowXtalInOvr(slowXtalInOvr),
  .slowXtalOutOvr(slowXtalOutOvr), .slowClkOut(slowClkOut));

// [verification/xoc_osc_partner.sv]
// partner: crystal and external clock sources on the oscillator pins
module xoc_osc_partner (
  input  wire logic mainOscRun,
  output logic      mainOscClkIn,
  output logic      slowXtalIn
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    mainOscClkIn = 1'b0;
    slowXtalIn = 1'b0;
  end
  // an unpowered crystal stands still
  always #3.1 mainOscClkIn = mainOscRun ? !mainOscClkIn : 1'b0;
  always #15.3 slowXtalIn = !slowXtalIn;
endmodule

// [verification/tb_xoc_crystal_osc_ctrl.sv]
// testbench: register-level scenarios for the oscillator control block
module tb_xoc_crystal_osc_ctrl
  import xoc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic        sys_clk = 1'b0, rst_b = 1'b0, regWrStb = 1'b0, regRdStb = 1'b0;
  logic        periphClkReq = 1'b0, mainOscRun, mainOscClkIn, mainOscClkOut, slowXtalIn;
  logic        slowOscRun, slowXtalMode, slowXtalInOvr, slowXtalOutOvr, slowClkOut, irqOut;
  logic [1:0]  sleepMode = 2'h0;
  logic [7:0]  regAddr = 8'h00;
  logic [31:0] regWrData = 32'h0, regRdData, rd;
  int          failures = 0, compares = 0;
  // ====
  // harness
  xoc_crystal_osc_ctrl i_xoc_crystal_osc_ctrl (.sys_clk(sys_clk), .rst_b(rst_b),
    .regAddr(regAddr), .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
    .sleepMode(sleepMode), .periphClkReq(periphClkReq), .mainOscClkIn(mainOscClkIn),
    .slowXtalIn(slowXtalIn), .regRdData(regRdData), .mainOscRun(mainOscRun),
    .mainOscClkOut(mainOscClkOut), .slowOscRun(slowOscRun), .slowXtalMode(slowXtalMode),
    .slowXtalInOvr(slowXtalInOvr), .slowXtalOutOvr(slowXtalOutOvr),
    .slowClkOut(slowClkOut), .irqOut(irqOut));
  xoc_osc_partner i_xoc_osc_partner (.mainOscRun(mainOscRun), .mainOscClkIn(mainOscClkIn),
    .slowXtalIn(slowXtalIn));
  always #4 sys_clk = !sys_clk;
  // ====
  // tasks
  task automatic report_and_stop();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regWrData <= d;
    regWrStb <= 1'b1;
    @(posedge sys_clk);
    regWrStb <= 1'b0;
  endtask
  task automatic rd_reg(logic [7:0] a);
    @(posedge sys_clk);
    regAddr <= a;
    regRdStb <= 1'b1;
    tick(1);
    regRdStb <= 1'b0;
    rd = regRdData;
  endtask
  task automatic irq_step(logic [7:0] a, logic [31:0] d, logic e);
    wr(a, d);
    tick(2);
    chk("irq", e, irqOut);
  endtask
  // ====
  // scenarios
  task automatic t_reset();
    tick(1);
    chk("pins", 4'h0, {slowXtalInOvr, slowXtalOutOvr, slowOscRun, mainOscRun});
    rd_reg(8'h1c);
    chk("unmapped", 32'h0, rd);
    rd_reg(STATUS_ADDR);
    chk("status", 32'h0, rd);
  endtask
  task automatic t_settle();
    int n;
    n = 0;
    wr(IRQ_ENSET_ADDR, 32'h1);
    wr(MAIN_CTRL_ADDR, 32'h2002);
    while (mainOscRun !== 1'b1 && n < 20) begin
      tick(1);
      n++;
    end
    if (n == 20) begin
      failures++;
      report_and_stop();
    end
    n = 0;
    while (irqOut !== 1'b1 && n < 40) begin
      tick(1);
      n++;
    end
    if (n == 40) begin
      failures++;
      report_and_stop();
    end
    chk("settle", 32'h1, n >= 4);
    rd_reg(STATUS_ADDR);
    chk("ready", 32'h1, rd[MAIN_RDY_BIT]);
    n = 0;
    repeat (8) begin
      tick(1);
      n += mainOscClkOut;
    end
    chk("clock out", 32'h1, n > 0);
    irq_step(IRQ_ENCLR_ADDR, 32'h1, 1'b0);
    irq_step(IRQ_ENSET_ADDR, 32'h1, 1'b1);
    irq_step(IRQ_CLR_ADDR, 32'h1, 1'b0);
  endtask
  task automatic t_modes();
    // {expected run, request, standby run, on request, enable, sleep mode}
    logic [6:0]  tbl [10] = '{7'h01, 7'h45, 7'h06, 7'h0d, 7'h6d, 7'h2e, 7'h56, 7'h1e, 7'h7e,
                              7'h07};
    logic [31:0] d;
    foreach (tbl[i]) begin
      d = 32'h0;
      d[MAIN_STDBY_BIT] = tbl[i][4];
      d[MAIN_ONREQ_BIT] = tbl[i][3];
      d[MAIN_ENABLE_BIT] = tbl[i][2];
      @(posedge sys_clk);
      sleepMode <= tbl[i][1:0];
      periphClkReq <= tbl[i][5];
      wr(MAIN_CTRL_ADDR, d);
      tick(3);
      chk("run", tbl[i][6], mainOscRun);
      if (!tbl[i][6]) begin
        rd_reg(STATUS_ADDR);
        chk("ready off", 32'h0, rd[MAIN_RDY_BIT]);
      end
    end
  endtask
  task automatic t_slow();
    // external, crystal, disable keeping crystal select, all clear
    logic [31:0] w [4] = '{32'h2, 32'h6, 32'h4, 32'h0};
    logic [1:0]  e [4] = '{2'h2, 2'h3, 2'h0, 2'h0};
    int          n;
    foreach (w[i]) begin
      wr(SLOW_CTRL_ADDR, w[i]);
      tick(2);
      chk("slow pins", e[i], {slowXtalInOvr, slowXtalOutOvr});
      rd_reg(STATUS_ADDR);
      chk("slow run", e[i][1], rd[SLOW_RDY_BIT]);
      n = 0;
      repeat (8) begin
        tick(1);
        n += slowClkOut;
      end
      chk("slow clock", e[i][1], n > 0);
    end
  endtask
  initial begin
    repeat (3) @(posedge sys_clk);
    rst_b <= 1'b1;
    t_reset();
    t_settle();
    t_modes();
    t_slow();
    report_and_stop();
  end
endmodule
